// File: rtl/bulky_fifo_pkg.sv
// Contract
// - Retry interval counts cycle starts waited between busy retransmissions.
// - Retry count caps how often a busy-acknowledged packet is resent.
// - Retry, size, occupancy and receive port registers clear on reset.
// - Stream transmit size: 10 bits, four-quadlet units, upper half.
// - Stream receive size: 10 bits, four-quadlet units, lower half.
// - Satellite size fields sit like stream fields and are write-only.
// - Satellite offsets alias the stream size, occupancy and port registers.
// - Under processor ownership occupancy follows every quadlet.
// - Under data interface ownership occupancy updates at packet commit, release and receipt.
// - Transmit free field reports empty quadlet slots, 12 bits.
// - Receive count field reports queued quadlets, 12 bits.
// - Satellite occupancy reads the same fields in the same places.
// - Final port write tags the last word and commits the packet.
// - Each receive port read pops the next queued quadlet.
// - Reading an empty receive port repeats the last value, no underflow.
// - Data ports number bit 00 as the quadlet's most significant bit.
// - Faulty receive acks data error, else pending or complete by select.
package bulky_fifo_pkg;
    localparam int        ADR_W         = 9;
    localparam bit [8:0]  OFS_RETRY     = 9'h14c;
    localparam bit [8:0]  OFS_SIZE      = 9'h150;
    localparam bit [8:0]  OFS_OCC       = 9'h154;
    localparam bit [8:0]  OFS_SAT_SIZE  = 9'h158;
    localparam bit [8:0]  OFS_SAT_OCC   = 9'h15c;
    localparam bit [8:0]  OFS_PUSH_C    = 9'h160;
    localparam bit [8:0]  OFS_PUSH_F    = 9'h164;
    localparam bit [8:0]  OFS_POP       = 9'h168;
    localparam bit [8:0]  OFS_SAT_PUSHC = 9'h16c;
    localparam bit [8:0]  OFS_SAT_PUSHF = 9'h170;
    localparam bit [8:0]  OFS_SAT_POP   = 9'h174;
    localparam bit [8:0]  OFS_CTRL      = 9'h1a0;
    localparam int        RTY_INT_LSB   = 8;
    localparam int        RTY_CNT_LSB   = 0;
    localparam int        TX_SIZE_LSB   = 16;
    localparam int        RX_SIZE_LSB   = 0;
    localparam int        TX_FREE_LSB   = 16;
    localparam int        RX_CNT_LSB    = 0;
    localparam int        CTRL_OWN_BIT  = 0;
    localparam int        CTRL_PEND_BIT = 1;
    localparam bit [31:0] REG_RESET     = 32'h0000_0000;
    localparam bit [31:0] CTRL_RESET    = 32'h0000_0002;
    localparam bit [3:0]  ACK_COMPLETE  = 4'h1;
    localparam bit [3:0]  ACK_PENDING   = 4'h2;
    localparam bit [3:0]  ACK_BUSY      = 4'h4;
    localparam bit [3:0]  ACK_DATA_ERR  = 4'hd;

    typedef struct packed {
        logic        last;
        logic [31:0] data;
    } tx_word_type;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } ack_report_type;
endpackage

// File: rtl/bulky_fifo_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module bulky_fifo_host_port #(
    parameter int ADDR_W = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [8:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             tx_valid_o,
    output logic [31:0]      tx_data_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i,
    input  wire logic        link_ack_valid_i,
    input  wire logic [3:0]  link_ack_code_i,
    input  wire logic        cycle_start_i,
    input  wire logic        cycle_timer_en_i,
    output logic             tx_done_o,
    output logic [3:0]       tx_done_code_o,
    input  wire logic        rx_valid_i,
    input  wire logic [31:0] rx_data_i,
    input  wire logic        rx_last_i,
    input  wire logic        rx_error_i,
    output logic             rx_ready_o,
    output logic             rx_ack_valid_o,
    output logic [3:0]       rx_ack_code_o
);
    // ****************************************
    // Bus decode
    // ****************************************
    localparam int DEPTH = 1 << ADDR_W;
    typedef logic [ADDR_W:0] ptr_type;
    typedef enum logic [1:0] {SEND, WAIT_ACK, WAIT_GAP} tx_state_type;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
        return a[8:2] == o[8:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic        ack_ff;
    logic [31:0] dat_ff;
    wire  bus_req = cyc_i & stb_i & ~ack_ff;
    wire  wr_req  = bus_req & we_i;
    wire  rd_req  = bus_req & ~we_i;

    // Stream and satellite offsets reach one set of registers.
    wire  hit_retry = hit(adr_i, bulky_fifo_pkg::OFS_RETRY);
    wire  hit_size_rd = hit(adr_i, bulky_fifo_pkg::OFS_SIZE);
    wire  hit_size = hit_size_rd
                   | hit(adr_i, bulky_fifo_pkg::OFS_SAT_SIZE);
    wire  hit_occ = hit(adr_i, bulky_fifo_pkg::OFS_OCC)
                  | hit(adr_i, bulky_fifo_pkg::OFS_SAT_OCC);
    wire  hit_push_c = hit(adr_i, bulky_fifo_pkg::OFS_PUSH_C)
                     | hit(adr_i, bulky_fifo_pkg::OFS_SAT_PUSHC);
    wire  hit_push_f = hit(adr_i, bulky_fifo_pkg::OFS_PUSH_F)
                     | hit(adr_i, bulky_fifo_pkg::OFS_SAT_PUSHF);
    wire  hit_pop = hit(adr_i, bulky_fifo_pkg::OFS_POP)
                  | hit(adr_i, bulky_fifo_pkg::OFS_SAT_POP);
    wire  hit_ctrl = hit(adr_i, bulky_fifo_pkg::OFS_CTRL);

    // ****************************************
    // Software registers
    // ****************************************
    logic [7:0] rty_int_ff;
    logic [7:0] rty_cnt_ff;
    logic [9:0] tx_size_ff;
    logic [9:0] rx_size_ff;
    logic       own_bdi_ff;
    logic       pend_sel_ff;

    wire [31:0] img_retry = {16'h0000, rty_int_ff, rty_cnt_ff};
    wire [31:0] img_size  = {6'h00, tx_size_ff, 6'h00, rx_size_ff};
    wire [31:0] img_ctrl  = {30'h0000_0000, pend_sel_ff, own_bdi_ff};
    wire [31:0] nxt_retry = merge(img_retry, dat_i, sel_i);
    wire [31:0] nxt_size  = merge(img_size, dat_i, sel_i);
    wire [31:0] nxt_ctrl  = merge(img_ctrl, dat_i, sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rty_int_ff  <= bulky_fifo_pkg::REG_RESET[7:0];
            rty_cnt_ff  <= bulky_fifo_pkg::REG_RESET[7:0];
            tx_size_ff  <= bulky_fifo_pkg::REG_RESET[9:0];
            rx_size_ff  <= bulky_fifo_pkg::REG_RESET[9:0];
            own_bdi_ff  <= bulky_fifo_pkg::CTRL_RESET[0];
            pend_sel_ff <= bulky_fifo_pkg::CTRL_RESET[1];
        end else begin
            if (wr_req && hit_retry) begin
                rty_int_ff <= nxt_retry[bulky_fifo_pkg::RTY_INT_LSB +: 8];
                rty_cnt_ff <= nxt_retry[bulky_fifo_pkg::RTY_CNT_LSB +: 8];
            end
            if (wr_req && hit_size) begin
                tx_size_ff <= nxt_size[bulky_fifo_pkg::TX_SIZE_LSB +: 10];
                rx_size_ff <= nxt_size[bulky_fifo_pkg::RX_SIZE_LSB +: 10];
            end
            if (wr_req && hit_ctrl) begin
                own_bdi_ff  <= nxt_ctrl[bulky_fifo_pkg::CTRL_OWN_BIT];
                pend_sel_ff <= nxt_ctrl[bulky_fifo_pkg::CTRL_PEND_BIT];
            end
        end
    end

    // Size units are four quadlets; the memory depth caps the result.
    wire [12:0] depth_c = 13'(DEPTH);
    wire [12:0] tx_raw  = {1'b0, tx_size_ff, 2'b00};
    wire [12:0] rx_raw  = {1'b0, rx_size_ff, 2'b00};
    wire [12:0] tx_cap  = (tx_raw > depth_c) ? depth_c : tx_raw;
    wire [12:0] rx_cap  = (rx_raw > depth_c) ? depth_c : rx_raw;

    // ****************************************
    // Transmit FIFO and retry
    // ****************************************
    // Words stay in memory until the packet is acknowledged, so a busy
    // answer can replay the packet from its first word.
    bulky_fifo_pkg::tx_word_type tx_mem [DEPTH];
    ptr_type      tx_wr_ff;
    ptr_type      tx_commit_ff;
    ptr_type      tx_rd_ff;
    ptr_type      tx_rel_ff;
    tx_state_type state_ff;
    logic [7:0]   tries_ff;
    logic [7:0]   gap_ff;
    logic         tx_valid_ff;
    bulky_fifo_pkg::tx_word_type tx_out_ff;
    bulky_fifo_pkg::ack_report_type done_ff;

    wire [12:0] tx_used = 13'(ptr_type'(tx_wr_ff - tx_rel_ff));
    wire        tx_full = tx_used >= tx_cap;
    wire        push = wr_req & (hit_push_c | hit_push_f) & ~tx_full;
    wire        push_final = push & hit_push_f;
    wire        tx_take = tx_valid_ff & tx_ready_i;
    wire        tx_load = (state_ff == SEND) && (tx_rd_ff != tx_commit_ff)
                        && !(tx_valid_ff && tx_out_ff.last)
                        && (!tx_valid_ff || tx_ready_i);
    wire        is_busy = link_ack_code_i == bulky_fifo_pkg::ACK_BUSY;
    wire        do_retry = is_busy && cycle_timer_en_i
                         && (tries_ff < rty_cnt_ff);
    wire        tx_release = (state_ff == WAIT_ACK) && link_ack_valid_i
                           && !do_retry;

    always_ff @(posedge clk_i) begin
        if (push) begin
            tx_mem[tx_wr_ff[ADDR_W-1:0]] <= '{last: hit_push_f, data: dat_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_wr_ff     <= '0;
            tx_commit_ff <= '0;
        end else if (push) begin
            tx_wr_ff <= ptr_type'(tx_wr_ff + 1'b1);
            if (push_final) begin
                tx_commit_ff <= ptr_type'(tx_wr_ff + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_ff <= 1'b0;
            tx_out_ff   <= '0;
        end else if (tx_load) begin
            tx_valid_ff <= 1'b1;
            tx_out_ff   <= tx_mem[tx_rd_ff[ADDR_W-1:0]];
        end else if (tx_take) begin
            tx_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff  <= SEND;
            tx_rd_ff  <= '0;
            tx_rel_ff <= '0;
            tries_ff  <= '0;
            gap_ff    <= '0;
            done_ff   <= '0;
        end else begin
            done_ff.valid <= 1'b0;
            if (tx_load) begin
                tx_rd_ff <= ptr_type'(tx_rd_ff + 1'b1);
            end
            unique case (state_ff)
                SEND: begin
                    if (tx_take && tx_out_ff.last) begin
                        state_ff <= WAIT_ACK;
                    end
                end
                WAIT_ACK: begin
                    if (link_ack_valid_i && do_retry) begin
                        tries_ff <= tries_ff + 8'h01;
                        gap_ff   <= rty_int_ff;
                        tx_rd_ff <= tx_rel_ff;
                        state_ff <= WAIT_GAP;
                    end else if (tx_release) begin
                        tries_ff <= '0;
                        tx_rel_ff <= tx_rd_ff;
                        done_ff <= '{valid: 1'b1, code: link_ack_code_i};
                        state_ff <= SEND;
                    end
                end
                WAIT_GAP: begin
                    if (gap_ff == 8'h00) begin
                        state_ff <= SEND;
                    end else if (cycle_start_i) begin
                        gap_ff <= gap_ff - 8'h01;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Receive FIFO
    // ****************************************
    logic [31:0] rx_mem [DEPTH];
    ptr_type     rx_wr_ff;
    ptr_type     rx_rd_ff;
    logic [31:0] rx_hold_ff;
    logic        rx_ready_ff;
    bulky_fifo_pkg::ack_report_type rx_ack_ff;

    wire [12:0] rx_used = 13'(ptr_type'(rx_wr_ff - rx_rd_ff));
    wire        rx_empty = rx_used == 13'h0000;
    wire        rx_acc = rx_valid_i & rx_ready_ff;
    wire        pop = rd_req & hit_pop & ~rx_empty;
    wire [31:0] rx_head = rx_mem[rx_rd_ff[ADDR_W-1:0]];
    wire [12:0] rx_used_nxt = 13'(rx_used + {12'h000, rx_acc}
                                  - {12'h000, pop});
    wire [3:0]  rx_code = rx_error_i ? bulky_fifo_pkg::ACK_DATA_ERR
                        : pend_sel_ff ? bulky_fifo_pkg::ACK_PENDING
                        : bulky_fifo_pkg::ACK_COMPLETE;

    // Bit 00 of the quadlet is wire bit 31; data is never reordered.
    always_ff @(posedge clk_i) begin
        if (rx_acc) begin
            rx_mem[rx_wr_ff[ADDR_W-1:0]] <= rx_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_wr_ff    <= '0;
            rx_rd_ff    <= '0;
            rx_hold_ff  <= bulky_fifo_pkg::REG_RESET;
            rx_ready_ff <= 1'b0;
            rx_ack_ff   <= '0;
        end else begin
            rx_ready_ff <= rx_used_nxt < rx_cap;
            rx_ack_ff.valid <= rx_acc & rx_last_i;
            if (rx_acc) begin
                rx_wr_ff <= ptr_type'(rx_wr_ff + 1'b1);
            end
            if (rx_acc && rx_last_i) begin
                rx_ack_ff.code <= rx_code;
            end
            if (pop) begin
                rx_rd_ff   <= ptr_type'(rx_rd_ff + 1'b1);
                rx_hold_ff <= rx_head;
            end
        end
    end

    // ****************************************
    // Occupancy reporting
    // ****************************************
    // The shadow lags the pointers by one cycle so it samples them after
    // the quadlet or packet that triggered the update has landed.
    logic [11:0] tx_free_ff;
    logic [11:0] rx_cnt_ff;
    logic        tx_evt_ff;
    logic        rx_evt_ff;
    wire  [11:0] tx_free_now = (tx_cap > tx_used) ? 12'(tx_cap - tx_used)
                                                  : 12'h000;
    wire  [11:0] rx_cnt_now  = rx_used[11:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_free_ff <= '0;
            rx_cnt_ff  <= '0;
            tx_evt_ff  <= 1'b0;
            rx_evt_ff  <= 1'b0;
        end else begin
            tx_evt_ff <= push_final | tx_release;
            rx_evt_ff <= rx_acc & rx_last_i;
            if (!own_bdi_ff || tx_evt_ff) begin
                tx_free_ff <= tx_free_now;
            end
            if (!own_bdi_ff || rx_evt_ff) begin
                rx_cnt_ff <= rx_cnt_now;
            end
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    wire [31:0] img_occ = {4'h0, tx_free_ff, 4'h0, rx_cnt_ff};
    wire [31:0] rd_mux =
        hit_retry   ? img_retry :
        hit_size_rd ? img_size :
        hit_occ     ? img_occ :
        hit_pop     ? (rx_empty ? rx_hold_ff : rx_head) :
        hit_ctrl    ? img_ctrl : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= rd_req ? rd_mux : 32'h0000_0000;
        end
    end

    assign ack_o          = ack_ff;
    assign dat_o          = dat_ff;
    assign tx_valid_o     = tx_valid_ff;
    assign tx_data_o      = tx_out_ff.data;
    assign tx_last_o      = tx_out_ff.last;
    assign tx_done_o      = done_ff.valid;
    assign tx_done_code_o = done_ff.code;
    assign rx_ready_o     = rx_ready_ff;
    assign rx_ack_valid_o = rx_ack_ff.valid;
    assign rx_ack_code_o  = rx_ack_ff.code;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_busy_spent;
        state_ff == WAIT_ACK && link_ack_valid_i && is_busy
            && tries_ff >= rty_cnt_ff;
    endsequence

    a_timer_off_no_retry: assert property (
        (state_ff == WAIT_ACK && link_ack_valid_i && !cycle_timer_en_i)
        |=> state_ff == SEND && done_ff.valid)
        else $error("retry ran with cycle timer off");
    a_gap_holds_wait: assert property (
        (state_ff == WAIT_GAP && gap_ff != 8'h00) |=> state_ff == WAIT_GAP)
        else $error("retry left interval wait early");
    a_retry_limit_end: assert property (
        s_busy_spent |=> state_ff == SEND && done_ff.valid
            && done_ff.code == bulky_fifo_pkg::ACK_BUSY)
        else $error("busy packet not released after last retry");
    a_retry_rewinds: assert property (
        (state_ff == WAIT_ACK && link_ack_valid_i && do_retry)
        |=> tx_rd_ff == tx_rel_ff && tries_ff == $past(tries_ff) + 8'h01)
        else $error("retry did not rewind packet");
    a_reset_clears: assert property (disable iff (1'b0)
        rst_i |=> img_retry == 32'h0 && img_size == 32'h0
            && img_occ == 32'h0 && rx_hold_ff == 32'h0)
        else $error("registers not cleared by reset");
    a_final_commits: assert property (
        push_final |=> tx_commit_ff == tx_wr_ff && tx_mem[
            $past(tx_wr_ff[ADDR_W-1:0])].last)
        else $error("final write did not commit packet");
    a_micro_tracks: assert property (
        !own_bdi_ff |=> tx_free_ff == $past(tx_free_now))
        else $error("free count not updated per quadlet");
    a_bdi_packet_only: assert property (
        (own_bdi_ff && !tx_evt_ff && !rx_evt_ff)
        |=> $stable(tx_free_ff) && $stable(rx_cnt_ff))
        else $error("occupancy changed inside a packet");
    a_pop_advances: assert property (
        pop |=> rx_rd_ff == ptr_type'($past(rx_rd_ff) + 1'b1)
            && dat_o == $past(rx_head))
        else $error("receive read did not pop");
    a_empty_repeats: assert property (
        (rd_req && hit_pop && rx_empty)
        |=> dat_o == $past(rx_hold_ff) && $stable(rx_rd_ff))
        else $error("empty receive read changed state");
    a_rx_ack_code: assert property (
        (rx_acc && rx_last_i && rx_error_i)
        |=> rx_ack_valid_o && rx_ack_code_o == bulky_fifo_pkg::ACK_DATA_ERR)
        else $error("faulty packet not acked as data error");
    a_alias_push: assert property (
        (wr_req && hit(adr_i, bulky_fifo_pkg::OFS_SAT_PUSHC) && !tx_full)
        |=> tx_wr_ff == ptr_type'($past(tx_wr_ff) + 1'b1))
        else $error("alias push offset ignored");
endmodule
`default_nettype wire

// File: sim/link_partner.sv
`timescale 1ns/100ps
`default_nettype none
module link_partner (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  tx_valid_i,
    input  wire logic  tx_last_i,
    input  wire logic  busy_i,
    output logic       tx_ready_o,
    output logic       ack_valid_o,
    output logic [3:0] ack_code_o,
    output logic       cycle_start_o
);
    logic [2:0] cnt_ff;
    logic       sent_ff;

    // Ready toggles so that every packet meets a stalling transmitter.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff      <= 3'h0;
            sent_ff     <= 1'b0;
            tx_ready_o  <= 1'b0;
            ack_valid_o <= 1'b0;
            ack_code_o  <= 4'h0;
        end else begin
            cnt_ff      <= cnt_ff + 3'h1;
            sent_ff     <= tx_valid_i & tx_ready_o & tx_last_i;
            tx_ready_o  <= ~tx_ready_o;
            ack_valid_o <= sent_ff;
            // Outside a pulse the code flips, so a stale code matches only on alternate cycles.
            ack_code_o  <= !sent_ff ? ~ack_code_o :
                busy_i ? bulky_fifo_pkg::ACK_BUSY :
                bulky_fifo_pkg::ACK_COMPLETE;
        end
    end

    assign cycle_start_o = (cnt_ff == 3'h0);
endmodule
`default_nettype wire

// File: sim/tb_bulky_fifo_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_bulky_fifo_host_port;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        rx_valid_i = 0, rx_last_i = 0, rx_error_i = 0;
    logic        cycle_timer_en_i = 0, busy = 0;
    logic [8:0]  adr_i = 9'h000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, rx_data_i = 32'h0000_0000;
    logic [31:0] dat_o, tx_data_o, r;
    logic        ack_o, tx_valid_o, tx_last_o, tx_ready_i, tx_done_o;
    logic        link_ack_valid_i, cycle_start_i, rx_ready_o;
    logic        rx_ack_valid_o;
    logic [3:0]  link_ack_code_i, tx_done_code_o, rx_ack_code_o;
    logic [32:0] rq[$], tq[$], dq[$], aq[$];
    int          n_fail = 0, samples_checked = 0, seed = 14143;

    always #10 clk_i = ~clk_i;

    bulky_fifo_host_port #(.ADDR_W(6)) dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .tx_valid_o, .tx_data_o, .tx_last_o,
        .tx_ready_i, .link_ack_valid_i, .link_ack_code_i, .cycle_start_i,
        .cycle_timer_en_i, .tx_done_o, .tx_done_code_o, .rx_valid_i,
        .rx_data_i, .rx_last_i, .rx_error_i, .rx_ready_o, .rx_ack_valid_o,
        .rx_ack_code_o);

    link_partner far (
        .clk_i, .rst_i, .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o),
        .busy_i(busy), .tx_ready_o(tx_ready_i), .ack_valid_o(link_ack_valid_i),
        .ack_code_o(link_ack_code_i), .cycle_start_o(cycle_start_i));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [32:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic pop_chk(input string nm, input logic [32:0] s,
                           ref logic [32:0] q[$]);
        if (q.size() == 0) begin
            n_fail++;
            $display("BAD %s expected nothing seen %h", nm, s);
        end else chk(nm, s, q.pop_front());
    endtask

    task automatic test_done;
        if (rq.size() + tq.size() + dq.size() + aq.size() != 0) n_fail++;
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0)
            pop_chk("read", {1'b0, dat_o}, rq);
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            pop_chk("tx", {tx_last_o, tx_data_o}, tq);
        if (tx_done_o === 1'b1)
            pop_chk("done", {29'h0, tx_done_code_o}, dq);
        if (rx_ack_valid_o === 1'b1)
            pop_chk("rxack", {29'h0, rx_ack_code_o}, aq);
    end

    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (s !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic wb(input logic w, input logic [8:0] a,
                      input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        wait_hi(ack_o);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        rq.push_back({1'b0, e});
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic pkt(input int nc, input int sends, input logic [3:0] c,
                       input int own);
        logic [31:0] w [4];
        for (int i = 0; i <= nc; i++) w[i] = $random(seed);
        for (int s = 0; s < sends; s++)
            for (int i = 0; i <= nc; i++)
                tq.push_back({i == nc, w[i]});
        dq.push_back({29'h0, c});
        if (own != 0) wb(1'b1, bulky_fifo_pkg::OFS_CTRL, 32'h0000_0003);
        for (int i = 0; i < nc; i++)
            wb(1'b1, i[0] ? bulky_fifo_pkg::OFS_SAT_PUSHC
                          : bulky_fifo_pkg::OFS_PUSH_C, w[i]);
        rd(bulky_fifo_pkg::OFS_OCC,
           32'h0008_0000 - ((own != 0 ? 0 : nc) << 16));
        wb(1'b1, own != 0 ? bulky_fifo_pkg::OFS_SAT_PUSHF
                          : bulky_fifo_pkg::OFS_PUSH_F, w[nc]);
        rd(bulky_fifo_pkg::OFS_OCC,
           32'h0008_0000 - ((nc + 1) << 16));
        wait_hi(tx_done_o);
        @(posedge clk_i);
        rd(bulky_fifo_pkg::OFS_SAT_OCC, 32'h0008_0000);
    endtask

    initial begin
        logic [8:0]  ra [7];
        logic [3:0]  ac [3];
        logic [31:0] d [3];
        ra = '{bulky_fifo_pkg::OFS_RETRY, bulky_fifo_pkg::OFS_SIZE,
               bulky_fifo_pkg::OFS_OCC, bulky_fifo_pkg::OFS_SAT_SIZE,
               bulky_fifo_pkg::OFS_SAT_OCC, bulky_fifo_pkg::OFS_POP, 9'h1fc};
        ac = '{bulky_fifo_pkg::ACK_PENDING, bulky_fifo_pkg::ACK_DATA_ERR,
               bulky_fifo_pkg::ACK_COMPLETE};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i]) rd(ra[i], 32'h0000_0000);
        $display("reset values test done");
        r = $random(seed);
        wb(1'b1, bulky_fifo_pkg::OFS_RETRY, r);
        rd(bulky_fifo_pkg::OFS_RETRY, r & 32'h0000_ffff);
        wb(1'b1, bulky_fifo_pkg::OFS_SAT_SIZE, 32'h0002_0002);
        rd(bulky_fifo_pkg::OFS_SIZE, 32'h0002_0002);
        rd(bulky_fifo_pkg::OFS_SAT_SIZE, 32'h0000_0000);
        $display("register test done");
        wb(1'b1, bulky_fifo_pkg::OFS_RETRY, 32'h0000_0101);
        pkt(2, 1, bulky_fifo_pkg::ACK_COMPLETE, 0);
        busy <= 1'b1;
        for (int en = 1; en >= 0; en--) begin
            cycle_timer_en_i <= en[0];
            pkt(1, 1 + en, bulky_fifo_pkg::ACK_BUSY, 1 - en);
        end
        busy <= 1'b0;
        $display("transmit test done");
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wb(1'b1, bulky_fifo_pkg::OFS_CTRL, 32'h0000_0000);
            aq.push_back({29'h0, ac[k]});
            for (int i = 0; i < 3; i++) begin
                d[i] = $random(seed);
                rx_valid_i <= 1'b1;
                rx_data_i  <= d[i];
                rx_last_i  <= (i == 2);
                rx_error_i <= (k == 1);
                @(posedge clk_i);
                wait_hi(rx_ready_o);
            end
            rx_valid_i <= 1'b0;
            rx_data_i  <= ~d[2];
            repeat (3) @(posedge clk_i);
            rd(bulky_fifo_pkg::OFS_SAT_OCC, 32'h0008_0003);
            rd(bulky_fifo_pkg::OFS_POP, d[0]);
            rd(bulky_fifo_pkg::OFS_SAT_POP, d[1]);
            rd(bulky_fifo_pkg::OFS_POP, d[2]);
            rd(bulky_fifo_pkg::OFS_POP, d[2]);
        end
        $display("receive test done");
        test_done();
    end
endmodule
`default_nettype wire
